//--- src/ubq_top.sv
`timescale 1ns/10ps
// Behaviour
// [RQ1] Without unlimited mode a written length above 62 is stored as 62.
// [RQ2] With unlimited mode lengths up to 255 are stored unchanged.
// [RQ3] Lengths above six are completed with alternating D3h, C2h fill bytes.
// [RQ4] Queues default to length 00h and alternating D3h, C2h data.
// [RQ5] Host writes may start anywhere; writes beyond location 6 are dropped.
// [RQ6] The load slot is never sent and can be read back by command C1h.
// [RQ7] Command B0h advances the load slot, releasing the previous slot to send.
// [RQ8] Load and send slot pointers wrap from 3 to 0.
// [RQ9] Full is shown when the load slot is one behind the send slot.
// [RQ10] Advancing while full is refused and sets transmit overflow.
// [RQ11] Empty is shown while both slot pointers are equal.
// [RQ12] Sending starts with queue mode, a loaded slot and enough receive space, or with unlimited mode in place of the space.
// [RQ13] A started message is sent whole, then its slot returns to defaults.
// [RQ14] A 62-byte ring is written by the receiver and read by the host.
// [RQ15] Ring pointers reset to 00h, 01h and 00h and are read only.
// [RQ16] Empty ring when read pointer is one below write; reads return zero.
// [RQ17] Receive clear resets pointers, zeroes the ring and resets the receiver.
// [RQ18] After a receive clear a preamble or byte-long idle resynchronises first.
// [RQ19] Preambles are not stored; data bytes are stored until stop or preamble.
// [RQ20] Stop stores a null byte and sets stop status, cleared on empty or preamble.
// [RQ21] First, error and last flags are shown for the byte at the read side.
// [RQ22] Data outside a preamble-framed message is discarded.
// [RQ23] Transmit clear zeroes both slot pointers and restores all queue defaults.
// [RQ24] A full ring overwrites its last slot and sets receive overflow until read.
// [RQ25] The interrupt stays asserted while any enabled flag is set.
// [RQ26] After a message is sent the send slot pointer advances.
module ubq_top
  import ubq_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Host command port
  input wire logic CMD_START,
  input wire logic [7:0] CMD_CODE,
  input wire logic BYTE_STB,
  input wire logic [7:0] BYTE_IN,
  output logic [7:0] BYTE_OUT,
  // Configuration
  input wire logic QUEUE_EN,
  input wire logic UNLIMITED,
  input wire logic TX_OVF_CLR,
  input wire logic [3:0] INT_EN,
  // Status
  output logic TX_FULL,
  output logic TX_EMPTY,
  output logic TX_OVF,
  output logic [1:0] LOAD_SLOT,
  output logic [1:0] SEND_SLOT,
  output logic RX_EMPTY,
  output logic RX_STOP,
  output logic RX_OVF,
  output logic FIRST_BYTE,
  output logic BYTE_ERROR,
  output logic LAST_BYTE,
  output logic [7:0] RX_RD_PTR,
  output logic [7:0] RX_WR_PTR,
  output logic [7:0] RX_NXT_PTR,
  output logic INT_N,
  // Receive link from the decoder
  input wire logic RX_LCLK,
  input wire logic [1:0] RX_LKIND,
  input wire logic [7:0] RX_LDATA,
  input wire logic RX_LERR,
  // Transmit byte stream to the encoder
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  output logic TX_LAST,
  input wire logic TX_READY
);

  typedef enum logic [1:0] {HM_IDLE, HM_WRQ, HM_RDQ, HM_RDRX} ubq_hmode_t;
  typedef enum logic [1:0] {TS_IDLE, TS_SEND, TS_DONE} ubq_tstate_t;

  ubq_txq_if tq ();
  ubq_rxr_if rq ();

  ubq_txq u_txq (
    .clk (CLK),
    .rst_n (RSTN),
    .q (tq.mem)
  );

  ubq_rxr u_rxr (
    .clk (CLK),
    .rst_n (RSTN),
    .r (rq.mem)
  );

  // ==========================================================
  // Link synchroniser
  logic [11:0] lk_s1_q;
  logic [11:0] lk_s2_q;
  logic lclk_q;
  logic lk_stb;
  ubq_kind_t lk_kind;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      lk_s1_q <= 12'h000;
      lk_s2_q <= 12'h000;
      lclk_q <= 1'b0;
    end
    else
    begin
      lk_s1_q <= {RX_LCLK, RX_LKIND, RX_LDATA, RX_LERR};
      lk_s2_q <= lk_s1_q;
      lclk_q <= lk_s2_q[11];
    end
  end

  assign lk_stb = lk_s2_q[11] & ~lclk_q;
  assign lk_kind = ubq_kind_t'(lk_s2_q[10:9]);

  // ==========================================================
  // Host and receive state
  ubq_hmode_t hmode_q, hmode_d;
  logic [2:0] loc_q, loc_d;
  logic wrok_q, wrok_d;
  logic [1:0] ld_q, ld_d;
  logic txovf_q, txovf_d;
  logic [7:0] out_q, out_d;
  logic [5:0] rd_q, rd_d, wr_q, wr_d, nxt_q, nxt_d;
  logic rxstop_q, rxstop_d, rxovf_q, rxovf_d;
  logic inframe_q, inframe_d, first_q, first_d, synced_q, synced_d;
  logic [IDLE_W-1:0] idle_q, idle_d;
  logic [1:0] tx_q, tx_d;
  logic tx_clear, rx_clear, tx_full, tx_empty, rx_empty, rx_full;
  logic [6:0] rx_space;
  logic [7:0] msg_len;

  assign tx_clear = CMD_START && (CMD_CODE == CMD_CLR_TX);
  assign rx_clear = CMD_START && (CMD_CODE == CMD_CLR_RX);
  assign tx_full = ((ld_q + 2'h1) == tx_q); // [RQ9]
  assign tx_empty = (ld_q == tx_q); // [RQ11]
  assign rx_empty = (ubq_rx_inc(rd_q) == wr_q); // [RQ16]
  assign rx_full = (wr_q == rd_q);
  assign rx_space = (wr_q <= rd_q) ? {1'b0, rd_q} - {1'b0, wr_q}
    : {1'b0, rd_q} + RX_DEPTH_W - {1'b0, wr_q};

  assign tq.clear = tx_clear;
  assign tq.unl = UNLIMITED;
  assign tq.wr_slot = ld_q;
  assign tq.wr_loc = loc_q;
  assign tq.wr_data = BYTE_IN;
  assign tq.rd_slot_a = ld_q; // [RQ6]
  assign tq.rd_loc_a = loc_q;
  assign rq.clear = rx_clear;
  assign rq.rd_addr = ubq_rx_inc(rd_q);

  always_comb
  begin
    hmode_d = hmode_q;
    loc_d = loc_q;
    wrok_d = wrok_q;
    ld_d = ld_q;
    txovf_d = txovf_q & ~TX_OVF_CLR;
    out_d = out_q;
    rd_d = rd_q;
    wr_d = wr_q;
    nxt_d = nxt_q;
    rxstop_d = rxstop_q & ~rx_empty; // [RQ20]
    rxovf_d = rxovf_q;
    inframe_d = inframe_q;
    first_d = first_q;
    synced_d = synced_q;
    idle_d = (idle_q == IDLE_W'(IDLE_CYCLES)) ? idle_q : idle_q + 1'b1;
    tq.wr_en = 1'b0;
    rq.wr_en = 1'b0;
    rq.wr_addr = wr_q;
    rq.wr_word = {lk_s2_q[0], 1'b0, first_q, lk_s2_q[8:1]};
    if (CMD_START)
    begin
      hmode_d = HM_IDLE;
      loc_d = CMD_CODE[3:1]; // [RQ5]
      if (CMD_CODE >= CMD_WR_LDQ && CMD_CODE <= CMD_WR_LDQ_END && !CMD_CODE[0])
      begin
        hmode_d = HM_WRQ;
        if (tx_full)
        begin
          txovf_d = 1'b1; // [RQ10]
          wrok_d = 1'b0;
        end
        else
        begin
          ld_d = ld_q + 2'h1; // [RQ7] [RQ8]
          wrok_d = 1'b1;
        end
      end
      else if (CMD_CODE >= CMD_RD_LDQ && CMD_CODE <= CMD_RD_LDQ_END && CMD_CODE[0])
        hmode_d = HM_RDQ; // [RQ6]
      else if (CMD_CODE == CMD_RD_RX)
        hmode_d = HM_RDRX;
      else if (CMD_CODE == CMD_RD_MSG)
      begin
        hmode_d = HM_RDRX;
        rd_d = nxt_q;
      end
      else if (tx_clear)
      begin
        ld_d = SLOT_RST; // [RQ23]
        txovf_d = 1'b0;
      end
    end
    else if (BYTE_STB)
    begin
      case (hmode_q)
        HM_WRQ:
        begin
          tq.wr_en = wrok_q && (loc_q <= LAST_LOC); // [RQ5]
          loc_d = (loc_q > LAST_LOC) ? loc_q : loc_q + 3'h1;
        end
        HM_RDQ:
        begin
          out_d = tq.rd_data_a;
          loc_d = (loc_q > LAST_LOC) ? loc_q : loc_q + 3'h1;
        end
        HM_RDRX:
        begin
          if (rx_empty)
            out_d = 8'h00; // [RQ16]
          else
          begin
            out_d = rq.rd_word[7:0];
            rd_d = ubq_rx_inc(rd_q);
            rxovf_d = 1'b0; // [RQ24]
            if (rq.rd_word[9])
              nxt_d = ubq_rx_inc(rd_q);
          end
        end
        default:
          out_d = out_q;
      endcase
    end
    if (lk_stb)
    begin
      idle_d = '0;
      case (lk_kind)
        LK_PRE:
        begin
          if (synced_q)
          begin
            inframe_d = 1'b1; // [RQ19]
            first_d = 1'b1;
            rxstop_d = 1'b0; // [RQ20]
          end
          else
            synced_d = 1'b1; // [RQ18]
        end
        LK_DATA, LK_STOP:
        begin
          if (inframe_q)
          begin
            rq.wr_en = 1'b1; // [RQ19] [RQ22]
            first_d = 1'b0;
            if (lk_kind == LK_STOP)
            begin
              rq.wr_word = {lk_s2_q[0], 1'b1, first_q, 8'h00}; // [RQ20] [RQ21]
              inframe_d = 1'b0;
              rxstop_d = 1'b1;
            end
            if (rx_full)
            begin
              rq.wr_addr = ubq_rx_dec(wr_q); // [RQ24]
              rxovf_d = 1'b1;
            end
            else
              wr_d = ubq_rx_inc(wr_q);
          end
        end
        default:
          inframe_d = inframe_q;
      endcase
    end
    else if (idle_q == IDLE_W'(IDLE_CYCLES))
      synced_d = 1'b1; // [RQ18]
    if (rx_clear)
    begin
      rd_d = RD_PTR_RST; // [RQ17]
      wr_d = WR_PTR_RST;
      nxt_d = NXT_PTR_RST;
      rxstop_d = 1'b0;
      rxovf_d = 1'b0;
      inframe_d = 1'b0;
      first_d = 1'b0;
      synced_d = 1'b0; // [RQ18]
      idle_d = '0;
      rq.wr_en = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hmode_q <= HM_IDLE;
      loc_q <= 3'h0;
      wrok_q <= 1'b0;
      ld_q <= SLOT_RST;
      txovf_q <= 1'b0;
      out_q <= 8'h00;
      rd_q <= RD_PTR_RST; // [RQ15]
      wr_q <= WR_PTR_RST;
      nxt_q <= NXT_PTR_RST;
      rxstop_q <= 1'b0;
      rxovf_q <= 1'b0;
      inframe_q <= 1'b0;
      first_q <= 1'b0;
      synced_q <= 1'b0;
      idle_q <= '0;
    end
    else
    begin
      hmode_q <= hmode_d;
      loc_q <= loc_d;
      wrok_q <= wrok_d;
      ld_q <= ld_d;
      txovf_q <= txovf_d;
      out_q <= out_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      nxt_q <= nxt_d;
      rxstop_q <= rxstop_d;
      rxovf_q <= rxovf_d;
      inframe_q <= inframe_d;
      first_q <= first_d;
      synced_q <= synced_d;
      idle_q <= idle_d;
    end
  end

  // ==========================================================
  // Transmit sequencer
  ubq_tstate_t ts_q, ts_d;
  logic [7:0] len_q, len_d, idx_q, idx_d, byte_q, byte_d;
  logic valid_q, valid_d, last_q, last_d;
  logic [7:0] nidx;

  assign nidx = idx_q + 8'h01;
  assign msg_len = tq.rd_data_b;
  assign tq.rd_slot_b = tx_q;
  assign tq.rd_loc_b = (ts_q == TS_IDLE || nidx > 8'(LAST_LOC)) ? 3'h0 : nidx[2:0];
  assign tq.restore = (ts_q == TS_DONE);
  assign tq.restore_slot = tx_q;

  always_comb
  begin
    ts_d = ts_q;
    len_d = len_q;
    idx_d = idx_q;
    byte_d = byte_q;
    valid_d = valid_q;
    last_d = last_q;
    tx_d = tx_q;
    case (ts_q)
      TS_IDLE:
      begin
        if (QUEUE_EN && !tx_empty && (UNLIMITED || {1'b0, rx_space} >= msg_len)) // [RQ12]
        begin
          ts_d = TS_SEND;
          len_d = msg_len;
          idx_d = 8'h00;
        end
      end
      TS_SEND:
      begin
        if (!valid_q || TX_READY)
        begin
          if (idx_q == len_q)
          begin
            ts_d = TS_DONE; // [RQ13]
            valid_d = 1'b0;
            last_d = 1'b0;
          end
          else
          begin
            idx_d = nidx;
            valid_d = 1'b1;
            last_d = (nidx == len_q);
            byte_d = (nidx > 8'(LAST_LOC)) ? ubq_dflt(nidx) : tq.rd_data_b; // [RQ3]
          end
        end
      end
      TS_DONE:
      begin
        ts_d = TS_IDLE;
        tx_d = tx_q + 2'h1; // [RQ26] [RQ8]
      end
      default:
        ts_d = TS_IDLE;
    endcase
    if (tx_clear)
    begin
      ts_d = TS_IDLE; // [RQ23]
      valid_d = 1'b0;
      last_d = 1'b0;
      tx_d = SLOT_RST;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ts_q <= TS_IDLE;
      len_q <= 8'h00;
      idx_q <= 8'h00;
      byte_q <= 8'h00;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      tx_q <= SLOT_RST;
    end
    else
    begin
      ts_q <= ts_d;
      len_q <= len_d;
      idx_q <= idx_d;
      byte_q <= byte_d;
      valid_q <= valid_d;
      last_q <= last_d;
      tx_q <= tx_d;
    end
  end

  // ==========================================================
  // Outputs
  assign BYTE_OUT = out_q;
  assign TX_FULL = tx_full;
  assign TX_EMPTY = tx_empty;
  assign TX_OVF = txovf_q;
  assign LOAD_SLOT = ld_q;
  assign SEND_SLOT = tx_q;
  assign RX_EMPTY = rx_empty;
  assign RX_STOP = rxstop_q;
  assign RX_OVF = rxovf_q;
  assign FIRST_BYTE = rq.rd_word[8]; // [RQ21]
  assign LAST_BYTE = rq.rd_word[9];
  assign BYTE_ERROR = rq.rd_word[10];
  assign RX_RD_PTR = {2'h0, rd_q};
  assign RX_WR_PTR = {2'h0, wr_q};
  assign RX_NXT_PTR = {2'h0, nxt_q};
  assign INT_N = ~|({rq.rd_word[10], rxovf_q, rxstop_q, txovf_q} & INT_EN); // [RQ25]
  assign TX_VALID = valid_q;
  assign TX_BYTE = byte_q;
  assign TX_LAST = last_q;

endmodule

//--- pkg/ubq_pkg.sv
package ubq_pkg;
  // ==========================================================
  // Buffer geometry
  localparam int QSLOTS = 4;
  localparam int QLOCS = 7;
  localparam int RX_DEPTH = 62;
  localparam logic [2:0] LAST_LOC = 3'h6;
  localparam logic [5:0] RX_LAST_ADDR = 6'h3D;
  localparam logic [6:0] RX_DEPTH_W = 7'h3E;
  // ==========================================================
  // Values
  localparam logic [7:0] LEN_MAX_STD = 8'h3E;
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic [7:0] FILL_ODD = 8'hD3;
  localparam logic [7:0] FILL_EVEN = 8'hC2;
  localparam logic [5:0] RD_PTR_RST = 6'h00;
  localparam logic [5:0] WR_PTR_RST = 6'h01;
  localparam logic [5:0] NXT_PTR_RST = 6'h00;
  localparam logic [1:0] SLOT_RST = 2'h0;
  // ==========================================================
  // Host commands
  localparam logic [7:0] CMD_CLR_TX = 8'h20;
  localparam logic [7:0] CMD_CLR_RX = 8'hE0;
  localparam logic [7:0] CMD_RD_RX = 8'h91;
  localparam logic [7:0] CMD_RD_MSG = 8'h93;
  localparam logic [7:0] CMD_WR_LDQ = 8'hB0;
  localparam logic [7:0] CMD_WR_LDQ_END = 8'hBC;
  localparam logic [7:0] CMD_RD_LDQ = 8'hC1;
  localparam logic [7:0] CMD_RD_LDQ_END = 8'hCD;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int IDLE_TIME_NS = 5000;
  localparam int IDLE_CYCLES = (IDLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
  // ==========================================================
  // Link character kinds
  typedef enum logic [1:0] {LK_NONE, LK_DATA, LK_PRE, LK_STOP} ubq_kind_t;

  // Default queue content, also the fill pattern past location 6.
  function automatic logic [7:0] ubq_dflt(input logic [7:0] idx);
    return (idx == 8'h00) ? LEN_RST : (idx[0] ? FILL_ODD : FILL_EVEN);
  endfunction

  function automatic logic [5:0] ubq_rx_inc(input logic [5:0] p);
    return (p == RX_LAST_ADDR) ? 6'h00 : p + 6'h01;
  endfunction

  function automatic logic [5:0] ubq_rx_dec(input logic [5:0] p);
    return (p == 6'h00) ? RX_LAST_ADDR : p - 6'h01;
  endfunction
endpackage

//--- pkg/ubq_if.sv
`timescale 1ns/10ps
interface ubq_txq_if;
  import ubq_pkg::*;
  logic clear;
  logic unl;
  logic wr_en;
  logic [1:0] wr_slot;
  logic [2:0] wr_loc;
  logic [7:0] wr_data;
  logic restore;
  logic [1:0] restore_slot;
  logic [1:0] rd_slot_a;
  logic [2:0] rd_loc_a;
  logic [7:0] rd_data_a;
  logic [1:0] rd_slot_b;
  logic [2:0] rd_loc_b;
  logic [7:0] rd_data_b;
  modport ctl (output clear, unl, wr_en, wr_slot, wr_loc, wr_data, restore, restore_slot,
    rd_slot_a, rd_loc_a, rd_slot_b, rd_loc_b, input rd_data_a, rd_data_b);
  modport mem (input clear, unl, wr_en, wr_slot, wr_loc, wr_data, restore, restore_slot,
    rd_slot_a, rd_loc_a, rd_slot_b, rd_loc_b, output rd_data_a, rd_data_b);
endinterface

interface ubq_rxr_if;
  import ubq_pkg::*;
  logic clear;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [10:0] wr_word;
  logic [5:0] rd_addr;
  logic [10:0] rd_word;
  modport ctl (output clear, wr_en, wr_addr, wr_word, rd_addr, input rd_word);
  modport mem (input clear, wr_en, wr_addr, wr_word, rd_addr, output rd_word);
endinterface

//--- src/ubq_txq.sv
`timescale 1ns/10ps
module ubq_txq
  import ubq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Queue access
  ubq_txq_if.mem q
);

  // ==========================================================
  // Queue storage
  logic [7:0] mem_q [QSLOTS][QLOCS];

  function automatic logic [7:0] clamp_len(input logic [7:0] v, input logic unl);
    return (!unl && v > LEN_MAX_STD) ? LEN_MAX_STD : v;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int s = 0; s < QSLOTS; s++)
        for (int l = 0; l < QLOCS; l++)
          mem_q[s][l] <= ubq_dflt(8'(l)); // [RQ4]
    end
    else
    begin
      for (int s = 0; s < QSLOTS; s++)
        for (int l = 0; l < QLOCS; l++)
          if (q.clear || (q.restore && q.restore_slot == 2'(s)))
            mem_q[s][l] <= ubq_dflt(8'(l)); // [RQ13] [RQ23]
          else if (q.wr_en && q.wr_slot == 2'(s) && q.wr_loc == 3'(l))
            mem_q[s][l] <= (l == 0) ? clamp_len(q.wr_data, q.unl) : q.wr_data; // [RQ1] [RQ2]
    end
  end

  // ==========================================================
  // Read ports, location 7 reads as zero
  assign q.rd_data_a = (q.rd_loc_a <= LAST_LOC) ? mem_q[q.rd_slot_a][q.rd_loc_a] : 8'h00;
  assign q.rd_data_b = (q.rd_loc_b <= LAST_LOC) ? mem_q[q.rd_slot_b][q.rd_loc_b] : 8'h00;

endmodule

//--- src/ubq_rxr.sv
`timescale 1ns/10ps
module ubq_rxr
  import ubq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Ring access
  ubq_rxr_if.mem r
);

  // ==========================================================
  // Ring storage: {error, last, first, data}
  logic [10:0] mem_q [RX_DEPTH];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < RX_DEPTH; i++)
        mem_q[i] <= 11'h000;
    end
    else if (r.clear)
    begin
      for (int i = 0; i < RX_DEPTH; i++)
        mem_q[i] <= 11'h000; // [RQ17]
    end
    else if (r.wr_en)
      mem_q[r.wr_addr] <= r.wr_word; // [RQ14]
  end

  assign r.rd_word = mem_q[r.rd_addr];

endmodule

//--- sim/ubq_top_properties.sv
`timescale 1ns/10ps
module ubq_top_chk
  import ubq_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Host side
  input wire logic CMD_START,
  input wire logic [7:0] CMD_CODE,
  input wire logic QUEUE_EN,
  input wire logic [3:0] INT_EN,
  // Status
  input logic TX_FULL,
  input logic TX_EMPTY,
  input logic TX_OVF,
  input logic [1:0] LOAD_SLOT,
  input logic [1:0] SEND_SLOT,
  input logic RX_EMPTY,
  input logic RX_STOP,
  input logic RX_OVF,
  input logic BYTE_ERROR,
  input logic [7:0] RX_RD_PTR,
  input logic [7:0] RX_WR_PTR,
  input logic [7:0] RX_NXT_PTR,
  input logic INT_N,
  // Transmit stream
  input logic TX_VALID,
  input logic [7:0] TX_BYTE,
  input wire logic TX_READY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  sequence adv_s;
    CMD_START && CMD_CODE == CMD_WR_LDQ;
  endsequence
  sequence stall_s;
    TX_VALID && !TX_READY;
  endsequence
  full_flag_a: assert property (TX_FULL == (LOAD_SLOT + 2'h1 == SEND_SLOT))
    else $error("full flag wrong");
  load_adv_a: assert property (adv_s ##0 !TX_FULL |=> LOAD_SLOT == $past(LOAD_SLOT) + 2'h1)
    else $error("load slot did not advance");
  full_refuse_a: assert property (adv_s ##0 TX_FULL |=> $stable(LOAD_SLOT) && TX_OVF)
    else $error("advance while full not refused");
  tx_clear_a: assert property (CMD_START && CMD_CODE == CMD_CLR_TX |=>
    LOAD_SLOT == 2'h0 && SEND_SLOT == 2'h0) else $error("transmit clear failed");
  rx_clear_a: assert property (CMD_START && CMD_CODE == CMD_CLR_RX |=>
    RX_RD_PTR == 8'h00 && RX_WR_PTR == 8'h01 && RX_NXT_PTR == 8'h00)
    else $error("receive clear failed");
  load_unsent_a: assert property (TX_VALID |-> SEND_SLOT != LOAD_SLOT)
    else $error("load slot being sent");
  start_cond_a: assert property ($rose(TX_VALID) |-> $past(QUEUE_EN) && !$past(TX_EMPTY))
    else $error("send started without cause");
  ring_empty_a: assert property (RX_EMPTY ==
    ((RX_RD_PTR == 8'h3D ? 8'h00 : RX_RD_PTR + 8'h01) == RX_WR_PTR))
    else $error("ring empty flag wrong");
  int_out_a: assert property (INT_N == !(|(INT_EN & {BYTE_ERROR, RX_OVF, RX_STOP, TX_OVF})))
    else $error("interrupt output wrong");
  byte_hold_a: assert property (stall_s |=> TX_VALID && $stable(TX_BYTE))
    else $error("stalled byte not held");
endmodule

bind ubq_top ubq_top_chk i_chk (.CLK(CLK), .RSTN(RSTN), .CMD_START(CMD_START),
  .CMD_CODE(CMD_CODE), .QUEUE_EN(QUEUE_EN), .INT_EN(INT_EN), .TX_FULL(TX_FULL),
  .TX_EMPTY(TX_EMPTY), .TX_OVF(TX_OVF), .LOAD_SLOT(LOAD_SLOT), .SEND_SLOT(SEND_SLOT),
  .RX_EMPTY(RX_EMPTY), .RX_STOP(RX_STOP), .RX_OVF(RX_OVF), .BYTE_ERROR(BYTE_ERROR),
  .RX_RD_PTR(RX_RD_PTR), .RX_WR_PTR(RX_WR_PTR), .RX_NXT_PTR(RX_NXT_PTR), .INT_N(INT_N),
  .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY));

//--- sim/ubq_link_model.sv
`timescale 1ns/10ps
module ubq_link_model
  import ubq_pkg::*;
(
  // Clock and stall request
  input wire logic clk,
  input wire logic stall,
  // Receive link toward the block
  output logic lclk,
  output logic [1:0] lkind,
  output logic [7:0] ldata,
  output logic lerr,
  // Transmit stream from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [8:0] got[$];
  initial
  begin
    lclk = 1'h0;
    {lkind, ldata, lerr} = 11'h000;
    tx_ready = 1'h0;
  end
  // ==========================================================
  // Link characters
  // One character per 64 ns; the link clock stands still between calls.
  // Past the hold time the lines show inverted values, never the old ones.
  task automatic put(input logic [1:0] k, input logic [7:0] d, input logic e);
    lkind = k;
    ldata = d;
    lerr = e;
    #32 lclk = 1'h1;
    #24;
    lkind = ~k;
    ldata = ~d;
    lerr = ~e;
    #8 lclk = 1'h0;
  endtask
  // ==========================================================
  // Transmit sink
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
    begin
      got.push_back({tx_last, tx_byte});
    end
    tx_ready <= !stall;
  end
endmodule

//--- sim/uart_tx_queue_rx_ring_buffer_tb.sv
`timescale 1ns/10ps
module uart_tx_queue_rx_ring_buffer_tb;
  import ubq_pkg::*;
  logic CLK = 1'h0;
  logic RSTN = 1'h0;
  logic CMD_START = 1'h0;
  logic [7:0] CMD_CODE = 8'h00;
  logic BYTE_STB = 1'h0;
  logic [7:0] BYTE_IN = 8'h00;
  logic QUEUE_EN = 1'h0;
  logic UNLIMITED = 1'h0;
  logic TX_OVF_CLR = 1'h0;
  logic [3:0] INT_EN = 4'hF;
  logic stall = 1'h0;
  logic [7:0] BYTE_OUT, RX_RD_PTR, RX_WR_PTR, RX_NXT_PTR, TX_BYTE, RX_LDATA;
  logic TX_FULL, TX_EMPTY, TX_OVF, RX_EMPTY, RX_STOP, RX_OVF, FIRST_BYTE, BYTE_ERROR;
  logic LAST_BYTE, INT_N, RX_LCLK, RX_LERR, TX_VALID, TX_LAST, TX_READY;
  logic [1:0] LOAD_SLOT, SEND_SLOT, RX_LKIND;
  int num_errors = 0;
  int comparisons = 0;

  always #2.5 CLK = ~CLK;

  ubq_top i_dut (.CLK(CLK), .RSTN(RSTN), .CMD_START(CMD_START), .CMD_CODE(CMD_CODE),
    .BYTE_STB(BYTE_STB), .BYTE_IN(BYTE_IN), .BYTE_OUT(BYTE_OUT), .QUEUE_EN(QUEUE_EN),
    .UNLIMITED(UNLIMITED), .TX_OVF_CLR(TX_OVF_CLR), .INT_EN(INT_EN), .TX_FULL(TX_FULL),
    .TX_EMPTY(TX_EMPTY), .TX_OVF(TX_OVF), .LOAD_SLOT(LOAD_SLOT), .SEND_SLOT(SEND_SLOT),
    .RX_EMPTY(RX_EMPTY), .RX_STOP(RX_STOP), .RX_OVF(RX_OVF), .FIRST_BYTE(FIRST_BYTE),
    .BYTE_ERROR(BYTE_ERROR), .LAST_BYTE(LAST_BYTE), .RX_RD_PTR(RX_RD_PTR),
    .RX_WR_PTR(RX_WR_PTR), .RX_NXT_PTR(RX_NXT_PTR), .INT_N(INT_N), .RX_LCLK(RX_LCLK),
    .RX_LKIND(RX_LKIND), .RX_LDATA(RX_LDATA), .RX_LERR(RX_LERR), .TX_VALID(TX_VALID),
    .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST), .TX_READY(TX_READY));

  ubq_link_model i_link (.clk(CLK), .stall(stall), .lclk(RX_LCLK), .lkind(RX_LKIND),
    .ldata(RX_LDATA), .lerr(RX_LERR), .tx_valid(TX_VALID), .tx_byte(TX_BYTE),
    .tx_last(TX_LAST), .tx_ready(TX_READY));

  // ==========================================================
  // Host port, link and check tasks
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // A command when st is set, otherwise one data byte phase.
  task automatic op(input logic st, input logic [7:0] v);
    @(posedge CLK);
    #1;
    CMD_START = st;
    CMD_CODE = v;
    BYTE_STB = !st;
    BYTE_IN = v;
    @(posedge CLK);
    #1;
    CMD_START = 1'h0;
    BYTE_STB = 1'h0;
  endtask

  task automatic wq(input logic [7:0] c, input logic [23:0] d);
    op(1'h1, c);
    op(1'h0, d[23:16]);
    op(1'h0, d[15:8]);
    op(1'h0, d[7:0]);
  endtask

  // Reads all seven locations of the load slot and one beyond.
  task automatic rdq(input logic [55:0] e);
    op(1'h1, CMD_RD_LDQ);
    for (int i = 6; i >= -1; i--)
    begin
      op(1'h0, 8'h00);
      chk(BYTE_OUT, i < 0 ? 8'h00 : e[i*8 +: 8]);
    end
  endtask

  task automatic lk(input logic [1:0] k, input logic [7:0] d, input logic e);
    i_link.put(k, d, e);
    repeat (4) @(posedge CLK);
    #1;
  endtask

  task automatic wait_slot(input logic [1:0] s);
    int n = 0;
    while (SEND_SLOT !== s && n < 4000)
    begin
      @(posedge CLK);
      #1;
      stall = n[2] & n[0];
      n++;
    end
    stall = 1'h0;
    chk(SEND_SLOT, s);
    if (n >= 4000)
      finish_test();
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge CLK);
    #1;
    RSTN = 1'h1;
    chk({RX_RD_PTR, RX_WR_PTR, RX_NXT_PTR}, 24'h00_0100);
    chk({TX_EMPTY, TX_FULL, RX_EMPTY, INT_N, LOAD_SLOT, SEND_SLOT}, 8'hB0);
    $display("Test reset finished");
    wq(CMD_WR_LDQ, 24'h80_57AA);
    chk({LOAD_SLOT, TX_EMPTY}, 3'h2);
    rdq(56'h3E_57AA_D3C2_D3C2);
    UNLIMITED = 1'h1;
    wq(CMD_WR_LDQ, 24'hFF_57AA);
    wq(CMD_WR_LDQ_END, 24'h11_2233);
    chk({LOAD_SLOT, TX_FULL}, 3'h7);
    rdq(56'h00_D3C2_D3C2_D311);
    wq(CMD_WR_LDQ, 24'h44_5566);
    chk({LOAD_SLOT, TX_OVF, INT_N}, 4'hE);
    INT_EN = 4'hE;
    rdq(56'h00_D3C2_D3C2_D311);
    chk(INT_N, 1'h1);
    INT_EN = 4'hF;
    TX_OVF_CLR = 1'h1;
    @(posedge CLK);
    #1;
    TX_OVF_CLR = 1'h0;
    chk({TX_OVF, INT_N}, 2'h1);
    UNLIMITED = 1'h0;
    QUEUE_EN = 1'h1;
    wait_slot(2'h1);
    repeat (20) @(posedge CLK);
    #1;
    chk({TX_VALID, SEND_SLOT, i_link.got.size()}, 35'h1_0000_0000);
    UNLIMITED = 1'h1;
    wait_slot(2'h3);
    chk({TX_EMPTY, i_link.got.size()}, 33'h1_0000_013D);
    for (int i = 0; i < 317; i++)
    begin
      int j;
      j = (i < 62) ? i + 1 : i - 61;
      chk(i_link.got[i], {j == ((i < 62) ? 62 : 255),
        j == 1 ? 8'h57 : j == 2 ? 8'hAA : j[0] ? FILL_ODD : FILL_EVEN});
    end
    QUEUE_EN = 1'h0;
    op(1'h1, CMD_WR_LDQ);
    chk(LOAD_SLOT, 2'h0);
    op(1'h1, CMD_WR_LDQ);
    rdq(56'h00_D3C2_D3C2_D3C2);
    wq(CMD_WR_LDQ, 24'h05_0102);
    op(1'h1, CMD_CLR_TX);
    chk({LOAD_SLOT, SEND_SLOT, TX_EMPTY}, 5'h01);
    op(1'h1, CMD_WR_LDQ);
    op(1'h1, CMD_WR_LDQ);
    rdq(56'h00_D3C2_D3C2_D3C2);
    $display("Test transmit queue finished");
    op(1'h1, CMD_CLR_RX);
    lk(LK_PRE, 8'h00, 1'h0);
    lk(LK_DATA, 8'h12, 1'h0);
    lk(LK_PRE, 8'h00, 1'h0);
    lk(LK_DATA, 8'h34, 1'h1);
    lk(LK_DATA, 8'h56, 1'h0);
    lk(LK_STOP, 8'h00, 1'h0);
    chk({RX_WR_PTR, RX_STOP}, 9'h009);
    chk({FIRST_BYTE, BYTE_ERROR, LAST_BYTE, INT_N, RX_EMPTY}, 5'h18);
    op(1'h1, CMD_RD_RX);
    op(1'h0, 8'h00);
    chk(BYTE_OUT, 8'h34);
    op(1'h1, CMD_RD_MSG);
    op(1'h0, 8'h00);
    chk({BYTE_OUT, RX_RD_PTR}, 16'h34_01);
    op(1'h0, 8'h00);
    chk({BYTE_OUT, LAST_BYTE}, 9'h0AD);
    op(1'h0, 8'h00);
    chk({BYTE_OUT, RX_EMPTY, RX_NXT_PTR}, 17'h0_0103);
    op(1'h0, 8'h00);
    chk({BYTE_OUT, RX_RD_PTR, RX_STOP}, 17'h0_0006);
    lk(LK_PRE, 8'h00, 1'h0);
    lk(LK_STOP, 8'h00, 1'h0);
    chk({RX_WR_PTR, FIRST_BYTE, LAST_BYTE, BYTE_ERROR}, 11'h02E);
    op(1'h1, CMD_CLR_RX);
    chk({RX_RD_PTR, RX_WR_PTR, RX_NXT_PTR, RX_EMPTY}, 25'h000_0201);
    lk(LK_PRE, 8'h00, 1'h0);
    lk(LK_PRE, 8'h00, 1'h0);
    for (int i = 1; i <= 62; i++)
      lk(LK_DATA, i[7:0], 1'h0);
    chk({RX_WR_PTR, RX_OVF, INT_N}, 10'h002);
    op(1'h1, CMD_RD_RX);
    op(1'h0, 8'h00);
    chk({BYTE_OUT, RX_OVF}, 9'h002);
    $display("Test receive ring finished");
    finish_test();
  end
endmodule
